// file: logic/emfb_flag_bank.sv
// sticky event flag bank with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "emfb_cfg.svh"

// How it works
// [RULE1] multiplier loop going locked to unlocked sets system clock flag bit 5.
// [RULE2] multiplier loop going unlocked to locked sets system clock flag bit 4.
// [RULE3] calibration start sets bit 0, calibration finish sets bit 1.
// [RULE4] distribution sync event sets misc flag bit 3.
// [RULE5] watchdog expiry sets misc flag bit 2.
// [RULE6] memory load or save fault sets misc flag bit 1.
// [RULE7] memory load or save success sets misc flag bit 0.
// [RULE8] loop starting a reference switchover sets loop flag bit 7.
// [RULE9] loop entering closed-loop operation sets loop flag bit 6.
// [RULE10] loop entering free run sets loop flag bit 5.
// [RULE11] loop entering holdover sets its own loop flag bit.
// [RULE12] frequency lock gained sets bit 2; lost sets its own bit.
// [RULE13] phase lock gained sets bit 0, phase lock lost sets bit 1.
// [RULE14] tuning word history update sets limiter flag bit 4.
// [RULE15] clamp entered sets limiter bit 2, clamp released sets bit 3.
// [RULE16] slew limiting start and stop each set their own limiter bit.
// [RULE17] inputs zero and one flag fault, cleared, validated, new profile.
// [RULE18] inputs two and three flag the same in the second register.
// [RULE19] a masked event never sets its flag.
// [RULE20] a flag stays set until clear, clear-all or reset.
// [RULE21] flag registers ignore software writes.
// [RULE22] unused bits and unused registers read zero.
module emfb_flag_bank (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire emfb_pkg::emfb_evt_type evt,
  input wire emfb_pkg::emfb_lvl_type lvl,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ---------------------------------------------------------------------------
  // constants and decode
  // ---------------------------------------------------------------------------
  localparam int N = `EMFB_NUM_FLAG_REGS;
  localparam logic [11:0] N12 = 12'(`EMFB_NUM_FLAG_REGS);
  localparam logic [N-1:0][7:0] VALID = {`EMFB_VALID_REF, `EMFB_VALID_REF, `EMFB_VALID_LIM,
                                         `EMFB_VALID_LOOP, `EMFB_VALID_MISC, `EMFB_VALID_SYS};

  // word index to register kind and slot; misaligned or high addresses miss
  function automatic emfb_pkg::emfb_dec_type emfb_decode(input logic [15:0] a);
    emfb_pkg::emfb_dec_type d;
    logic [11:0] w;
    logic [11:0] fo;
    logic [11:0] mo;
    logic [11:0] co;
    d.kind = emfb_pkg::EMFB_DEC_NONE;
    d.slot = 3'h0;
    w = a[13:2];
    fo = w - `EMFB_IDX_SYSTEM_CLOCK_MULTIPLIER_EVENT_FLAGS;
    mo = w - `EMFB_IDX_MASK_BASE;
    co = w - `EMFB_IDX_CLEAR_BASE;
    if (a[15:14] == 2'b00 && a[1:0] == 2'b00) begin
      if (fo < N12) begin
        d.kind = emfb_pkg::EMFB_DEC_FLAG;
        d.slot = fo[2:0];
      end else if (w == `EMFB_IDX_UNUSED_EVENT_SLOT_A || w == `EMFB_IDX_UNUSED_EVENT_SLOT_B) begin
        d.kind = emfb_pkg::EMFB_DEC_UNUSED;
      end else if (mo < N12) begin
        d.kind = emfb_pkg::EMFB_DEC_MASK;
        d.slot = mo[2:0];
      end else if (co < N12) begin
        d.kind = emfb_pkg::EMFB_DEC_CLEAR;
        d.slot = co[2:0];
      end else if (w == `EMFB_IDX_CLEAR_ALL) begin
        d.kind = emfb_pkg::EMFB_DEC_CLEAR_ALL;
      end
    end
    return d;
  endfunction

  emfb_pkg::emfb_state_type st_r;
  emfb_pkg::emfb_state_type st_nxt;
  emfb_pkg::emfb_dec_type dec;
  logic access;
  logic wr_lane;
  logic clr_all;
  logic [N-1:0][7:0] raw;
  logic [N-1:0][7:0] set_vec;
  logic [N-1:0][7:0] clr_vec;
  logic [7:0] read_byte;

  // ---------------------------------------------------------------------------
  // event wiring
  // ---------------------------------------------------------------------------
  // transitions come from the previous level, so a level already high at
  // reset release is reported as a fresh transition
  always_comb begin
    raw = '0;
    raw[`EMFB_SLOT_SYS][`EMFB_BIT_SYS_UNLOCKED] = st_r.prev.sys_mult_locked & ~lvl.sys_mult_locked; // [RULE1]
    raw[`EMFB_SLOT_SYS][`EMFB_BIT_SYS_LOCKED] = ~st_r.prev.sys_mult_locked & lvl.sys_mult_locked; // [RULE2]
    raw[`EMFB_SLOT_SYS][`EMFB_BIT_CALIBRATION_BEGUN_FLAG] = evt.cal_begun; // [RULE3]
    raw[`EMFB_SLOT_SYS][`EMFB_BIT_CALIBRATION_DONE_FLAG] = evt.cal_done; // [RULE3]
    raw[`EMFB_SLOT_MISC][`EMFB_BIT_DIST_SYNC] = evt.dist_sync; // [RULE4]
    raw[`EMFB_SLOT_MISC][`EMFB_BIT_WDOG] = evt.wdog_expired; // [RULE5]
    raw[`EMFB_SLOT_MISC][`EMFB_BIT_NVM_FAULT] = evt.nvm_fault; // [RULE6]
    raw[`EMFB_SLOT_MISC][`EMFB_BIT_NVM_DONE] = evt.nvm_done; // [RULE7]
    raw[`EMFB_SLOT_LOOP][`EMFB_BIT_SWITCHING] = evt.loop_switching; // [RULE8]
    raw[`EMFB_SLOT_LOOP][`EMFB_BIT_CLOSED] = evt.loop_closed; // [RULE9]
    raw[`EMFB_SLOT_LOOP][`EMFB_BIT_FREERUN] = evt.loop_freerun; // [RULE10]
    raw[`EMFB_SLOT_LOOP][`EMFB_BIT_HOLDOVER] = evt.loop_holdover; // [RULE11]
    raw[`EMFB_SLOT_LOOP][`EMFB_BIT_FREQ_LOCKED] = ~st_r.prev.freq_locked & lvl.freq_locked; // [RULE12]
    raw[`EMFB_SLOT_LOOP][`EMFB_BIT_FREQ_UNLOCKED] = st_r.prev.freq_locked & ~lvl.freq_locked; // [RULE12]
    raw[`EMFB_SLOT_LOOP][`EMFB_BIT_PHASE_LOCKED] = ~st_r.prev.phase_locked & lvl.phase_locked; // [RULE13]
    raw[`EMFB_SLOT_LOOP][`EMFB_BIT_PHASE_UNLOCKED] = st_r.prev.phase_locked & ~lvl.phase_locked; // [RULE13]
    raw[`EMFB_SLOT_LIM][`EMFB_BIT_HISTORY] = evt.history_updated; // [RULE14]
    raw[`EMFB_SLOT_LIM][`EMFB_BIT_CLAMPED] = ~st_r.prev.freq_clamped & lvl.freq_clamped; // [RULE15]
    raw[`EMFB_SLOT_LIM][`EMFB_BIT_UNCLAMPED] = st_r.prev.freq_clamped & ~lvl.freq_clamped; // [RULE15]
    raw[`EMFB_SLOT_LIM][`EMFB_BIT_SLEW_LIMITED] = ~st_r.prev.slew_limiting & lvl.slew_limiting; // [RULE16]
    raw[`EMFB_SLOT_LIM][`EMFB_BIT_SLEW_UNLIMITED] = st_r.prev.slew_limiting & ~lvl.slew_limiting; // [RULE16]
    // two inputs share each reference register, one nibble each
    for (int r = 0; r < 4; r++) begin
      raw[`EMFB_SLOT_REF_LOW + r / 2][(r % 2) * `EMFB_REF_STRIDE + `EMFB_BIT_REF_FAULT] =
        evt.ref_fault[r]; // [RULE17] [RULE18]
      raw[`EMFB_SLOT_REF_LOW + r / 2][(r % 2) * `EMFB_REF_STRIDE + `EMFB_BIT_REF_CLEARED] =
        evt.ref_fault_cleared[r]; // [RULE17] [RULE18]
      raw[`EMFB_SLOT_REF_LOW + r / 2][(r % 2) * `EMFB_REF_STRIDE + `EMFB_BIT_REF_VALID] =
        evt.ref_validated[r]; // [RULE17] [RULE18]
      raw[`EMFB_SLOT_REF_LOW + r / 2][(r % 2) * `EMFB_REF_STRIDE + `EMFB_BIT_REF_PROFILE] =
        evt.ref_new_profile[r]; // [RULE17] [RULE18]
    end
  end

  // ---------------------------------------------------------------------------
  // set and clear vectors
  // ---------------------------------------------------------------------------
  assign dec = emfb_decode(paddr);
  assign access = psel & penable;
  // writes land at the edge where pready is seen high, low byte lane only
  assign wr_lane = access & st_r.pready & pwrite & pstrb[0];
  assign clr_all = wr_lane & (dec.kind == emfb_pkg::EMFB_DEC_CLEAR_ALL) & pwdata[`EMFB_BIT_CLEAR_ALL]; // [RULE20]

  for (genvar k = 0; k < N; k++) begin : g_bank
    assign set_vec[k] = raw[k] & ~st_r.mask[k] & VALID[k]; // [RULE19] [RULE22]
    assign clr_vec[k] = {8{clr_all}} |
      ((wr_lane && dec.kind == emfb_pkg::EMFB_DEC_CLEAR && dec.slot == 3'(k)) ? pwdata[7:0] : 8'h00); // [RULE20]
  end

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  // clear registers are write-one strobes and read back zero
  always_comb begin
    read_byte = 8'h00;
    case (dec.kind)
      emfb_pkg::EMFB_DEC_FLAG: read_byte = (dec.slot < 3'(N)) ? st_r.flags[dec.slot] : 8'h00;
      emfb_pkg::EMFB_DEC_MASK: read_byte = (dec.slot < 3'(N)) ? st_r.mask[dec.slot] : 8'h00;
      emfb_pkg::EMFB_DEC_UNUSED: read_byte = 8'h00; // [RULE22]
      default: read_byte = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  // one wait state on every transfer keeps prdata straight from a flop
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = lvl;
    st_nxt.pready = access & ~st_r.pready;
    st_nxt.prdata = 32'h0000_0000;
    st_nxt.pslverr = 1'b0;
    if (access && !st_r.pready) begin
      st_nxt.prdata = {24'h00_0000, read_byte};
      st_nxt.pslverr = (dec.kind == emfb_pkg::EMFB_DEC_NONE);
    end
    for (int k = 0; k < N; k++) begin
      // set beats a clear in the same cycle so no event is lost
      st_nxt.flags[k] = (st_r.flags[k] & ~clr_vec[k]) | set_vec[k]; // [RULE20] [RULE21]
      if (wr_lane && dec.kind == emfb_pkg::EMFB_DEC_MASK && dec.slot == 3'(k)) begin
        st_nxt.mask[k] = pwdata[7:0] & VALID[k]; // [RULE22]
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
      st_r.flags <= {N{`EMFB_FLAG_RESET}}; // [RULE20]
      st_r.mask <= {N{`EMFB_MASK_RESET}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic any_clear;
  assign any_clear = wr_lane &&
    (dec.kind == emfb_pkg::EMFB_DEC_CLEAR || dec.kind == emfb_pkg::EMFB_DEC_CLEAR_ALL);

  property flag_sets(ev, k, b);
    ev && !st_r.mask[k][b] |=> st_r.flags[k][b];
  endproperty

  sequence apb_wait;
    psel && penable && !pready;
  endsequence

  sequence apb_answer;
    pready ##1 !pready;
  endsequence

  sys_unlock_flag_a: assert property (flag_sets(st_r.prev.sys_mult_locked && !lvl.sys_mult_locked, 0, 5)) // [RULE1]
    else $error("unlock transition did not set its flag");
  sys_lock_flag_a: assert property (flag_sets($rose(lvl.sys_mult_locked) && !st_r.prev.sys_mult_locked
    && $past(lvl.sys_mult_locked) == 1'b0, 0, 4)) // [RULE2]
    else $error("lock transition did not set its flag");
  cal_flags_a: assert property (evt.cal_begun && evt.cal_done && st_r.mask[0][1:0] == 2'b00
    |=> st_r.flags[0][1:0] == 2'b11) // [RULE3]
    else $error("calibration flags not set");
  dist_sync_flag_a: assert property (flag_sets(evt.dist_sync, 1, 3)) // [RULE4]
    else $error("distribution sync flag not set");
  wdog_flag_a: assert property (flag_sets(evt.wdog_expired, 1, 2)) // [RULE5]
    else $error("watchdog flag not set");
  nvm_fault_flag_a: assert property (flag_sets(evt.nvm_fault, 1, 1)) // [RULE6]
    else $error("memory fault flag not set");
  nvm_done_flag_a: assert property (flag_sets(evt.nvm_done, 1, 0)) // [RULE7]
    else $error("memory done flag not set");
  switch_flag_a: assert property (flag_sets(evt.loop_switching, 2, 7)) // [RULE8]
    else $error("switchover flag not set");
  closed_flag_a: assert property (flag_sets(evt.loop_closed, 2, 6)) // [RULE9]
    else $error("closed loop flag not set");
  freerun_flag_a: assert property (flag_sets(evt.loop_freerun, 2, 5)) // [RULE10]
    else $error("free run flag not set");
  holdover_flag_a: assert property (flag_sets(evt.loop_holdover, 2, 4)) // [RULE11]
    else $error("holdover flag not set");
  freq_lock_flags_a: assert property (st_r.prev.freq_locked != lvl.freq_locked && st_r.mask[2][3:2] == 2'b00
    |=> st_r.flags[2][3:2] != 2'b00) // [RULE12]
    else $error("frequency lock change not flagged");
  phase_lock_flags_a: assert property (!st_r.prev.phase_locked && lvl.phase_locked && !st_r.mask[2][0]
    |=> st_r.flags[2][0] ##1 (st_r.flags[2][0] || $past(any_clear))) // [RULE13]
    else $error("phase lock not flagged");
  history_flag_a: assert property (flag_sets(evt.history_updated, 3, 4)) // [RULE14]
    else $error("history flag not set");
  clamp_flag_a: assert property (flag_sets(!st_r.prev.freq_clamped && lvl.freq_clamped, 3, 2)) // [RULE15]
    else $error("clamp flag not set");
  slew_flag_a: assert property (flag_sets(st_r.prev.slew_limiting && !lvl.slew_limiting, 3, 1)) // [RULE16]
    else $error("slew stop flag not set");
  ref_low_flag_a: assert property (flag_sets(evt.ref_new_profile[1], 4, 7)) // [RULE17]
    else $error("input one profile flag not set");
  ref_high_flag_a: assert property (flag_sets(evt.ref_validated[2], 5, 2)) // [RULE18]
    else $error("input two validation flag not set");
  mask_blocks_a: assert property (!st_r.flags[2][6] && st_r.mask[2][6] |=> !st_r.flags[2][6]) // [RULE19]
    else $error("masked event set a flag");
  flag_sticky_a: assert property (st_r.flags[0][4] && !any_clear |=> st_r.flags[0][4] [*2] or
    st_r.flags[0][4] ##1 $past(any_clear)) // [RULE20]
    else $error("flag dropped without a clear");
  clear_all_a: assert property (clr_all && raw == '0 |=> st_r.flags == '0) // [RULE20]
    else $error("clear-all left a flag set");
  flag_ro_a: assert property (wr_lane && dec.kind == emfb_pkg::EMFB_DEC_FLAG
    |=> st_r.flags == ($past(st_r.flags) | $past(set_vec))) // [RULE21]
    else $error("write changed a flag register");
  unused_zero_a: assert property (apb_wait and dec.kind == emfb_pkg::EMFB_DEC_UNUSED
    |=> pready && prdata == 32'h0000_0000 && !pslverr) // [RULE22]
    else $error("unused register read not zero");
  unused_bits_a: assert property ((st_r.flags[0] & ~`EMFB_VALID_SYS) == 8'h00 &&
    (st_r.flags[3] & ~`EMFB_VALID_LIM) == 8'h00) // [RULE22]
    else $error("unused flag bit set");
  apb_one_wait_a: assert property (apb_wait |=> apb_answer)
    else $error("apb answer not after one wait state");

endmodule
`default_nettype wire

// file: include/emfb_cfg.svh
// offsets, bit positions, widths and reset values of the event flag bank
`ifndef EMFB_CFG_SVH
`define EMFB_CFG_SVH

// ---------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ---------------------------------------------------------------------------
`define EMFB_IDX_SYSTEM_CLOCK_MULTIPLIER_EVENT_FLAGS 12'hd02
`define EMFB_IDX_MISC_EVENT_FLAGS 12'hd03
`define EMFB_IDX_LOOP_EVENT_FLAGS 12'hd04
`define EMFB_IDX_LIMITER_EVENT_FLAGS 12'hd05
`define EMFB_IDX_REF_EVENT_FLAGS_LOW 12'hd06
`define EMFB_IDX_REF_EVENT_FLAGS_HIGH 12'hd07
`define EMFB_IDX_UNUSED_EVENT_SLOT_A 12'hd08
`define EMFB_IDX_UNUSED_EVENT_SLOT_B 12'hd09
`define EMFB_IDX_MASK_BASE 12'h209
`define EMFB_IDX_CLEAR_BASE 12'ha04
`define EMFB_IDX_CLEAR_ALL 12'ha03
`define EMFB_BIT_CLEAR_ALL 1
`define EMFB_NUM_FLAG_REGS 6

// ---------------------------------------------------------------------------
// slots of the flag registers inside the bank
// ---------------------------------------------------------------------------
`define EMFB_SLOT_SYS 0
`define EMFB_SLOT_MISC 1
`define EMFB_SLOT_LOOP 2
`define EMFB_SLOT_LIM 3
`define EMFB_SLOT_REF_LOW 4

// ---------------------------------------------------------------------------
// implemented bits of each flag register
// ---------------------------------------------------------------------------
`define EMFB_VALID_SYS 8'h33
`define EMFB_VALID_MISC 8'h0f
`define EMFB_VALID_LOOP 8'hff
`define EMFB_VALID_LIM 8'h1f
`define EMFB_VALID_REF 8'hff

// ---------------------------------------------------------------------------
// bit positions
// ---------------------------------------------------------------------------
`define EMFB_BIT_SYS_UNLOCKED 5
`define EMFB_BIT_SYS_LOCKED 4
`define EMFB_BIT_CALIBRATION_DONE_FLAG 1
`define EMFB_BIT_CALIBRATION_BEGUN_FLAG 0
`define EMFB_BIT_DIST_SYNC 3
`define EMFB_BIT_WDOG 2
`define EMFB_BIT_NVM_FAULT 1
`define EMFB_BIT_NVM_DONE 0
`define EMFB_BIT_SWITCHING 7
`define EMFB_BIT_CLOSED 6
`define EMFB_BIT_FREERUN 5
`define EMFB_BIT_HOLDOVER 4
`define EMFB_BIT_FREQ_UNLOCKED 3
`define EMFB_BIT_FREQ_LOCKED 2
`define EMFB_BIT_PHASE_UNLOCKED 1
`define EMFB_BIT_PHASE_LOCKED 0
`define EMFB_BIT_HISTORY 4
`define EMFB_BIT_UNCLAMPED 3
`define EMFB_BIT_CLAMPED 2
`define EMFB_BIT_SLEW_UNLIMITED 1
`define EMFB_BIT_SLEW_LIMITED 0
`define EMFB_BIT_REF_FAULT 0
`define EMFB_BIT_REF_CLEARED 1
`define EMFB_BIT_REF_VALID 2
`define EMFB_BIT_REF_PROFILE 3
`define EMFB_REF_STRIDE 4

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define EMFB_FLAG_RESET 8'h00
`define EMFB_MASK_RESET 8'h00

`endif

// file: include/emfb_pkg.sv
// types shared by the event flag bank
`include "emfb_cfg.svh"

package emfb_pkg;

  // one-cycle event pulses from the clock synchronizer core
  typedef struct packed {
    logic cal_begun;
    logic cal_done;
    logic dist_sync;
    logic wdog_expired;
    logic nvm_fault;
    logic nvm_done;
    logic loop_switching;
    logic loop_closed;
    logic loop_freerun;
    logic loop_holdover;
    logic history_updated;
    logic [3:0] ref_fault;
    logic [3:0] ref_fault_cleared;
    logic [3:0] ref_validated;
    logic [3:0] ref_new_profile;
  } emfb_evt_type;

  // status levels whose transitions are flagged
  typedef struct packed {
    logic sys_mult_locked;
    logic freq_locked;
    logic phase_locked;
    logic freq_clamped;
    logic slew_limiting;
  } emfb_lvl_type;

  typedef enum logic [2:0] {
    EMFB_DEC_NONE = 3'b000,
    EMFB_DEC_FLAG = 3'b001,
    EMFB_DEC_UNUSED = 3'b010,
    EMFB_DEC_MASK = 3'b011,
    EMFB_DEC_CLEAR = 3'b100,
    EMFB_DEC_CLEAR_ALL = 3'b101
  } emfb_dec_kind_type;

  typedef struct packed {
    emfb_dec_kind_type kind;
    logic [2:0] slot;
  } emfb_dec_type;

  typedef struct packed {
    logic [`EMFB_NUM_FLAG_REGS-1:0][7:0] flags;
    logic [`EMFB_NUM_FLAG_REGS-1:0][7:0] mask;
    emfb_lvl_type prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } emfb_state_type;

endpackage

// file: test/tb.sv
// self-checking testbench for the event flag bank
`timescale 1ns/1ps
`default_nettype none
`include "emfb_cfg.svh"

module tb;
  // ---------------------------------------------------------------------------
  // signals, clock and design
  // ---------------------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  emfb_pkg::emfb_evt_type evt = '0;
  emfb_pkg::emfb_lvl_type lvl = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int n_errors = 0;
  int check_count = 0;
  logic rnd_on = 1'b0;
  logic [5:0][7:0] exp_f;
  logic [5:0][7:0] exp_m;
  logic [5:0][7:0] clr;
  emfb_pkg::emfb_lvl_type prev;
  logic wr_ok;
  logic [11:0] ix;
  localparam logic [5:0][7:0] VALID = {8'hff, 8'hff, 8'h1f, 8'hff, 8'h0f, 8'h33};

  always #12.5 clk_sys = ~clk_sys;

  emfb_flag_bank emfb_flag_bank_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .evt(evt), .lvl(lvl),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ---------------------------------------------------------------------------
  // reference model of flags and masks
  // ---------------------------------------------------------------------------
  // flags raised this cycle by pulses and level edges, before masking
  function automatic logic [5:0][7:0] set_of(emfb_pkg::emfb_evt_type e, emfb_pkg::emfb_lvl_type l,
                                             emfb_pkg::emfb_lvl_type p);
    logic [5:0][7:0] s;
    emfb_pkg::emfb_lvl_type up;
    emfb_pkg::emfb_lvl_type dn;
    up = l & ~p;
    dn = p & ~l;
    s[0] = {2'h0, dn.sys_mult_locked, up.sys_mult_locked, 2'h0, e.cal_done, e.cal_begun};
    s[1] = {4'h0, e.dist_sync, e.wdog_expired, e.nvm_fault, e.nvm_done};
    s[2] = {e.loop_switching, e.loop_closed, e.loop_freerun, e.loop_holdover, dn.freq_locked,
            up.freq_locked, dn.phase_locked, up.phase_locked};
    s[3] = {3'h0, e.history_updated, dn.freq_clamped, up.freq_clamped, dn.slew_limiting, up.slew_limiting};
    for (int k = 0; k < 4; k++) begin
      s[4 + k / 2][(k % 2) * 4 +: 4] = {e.ref_new_profile[k], e.ref_validated[k], e.ref_fault_cleared[k],
                                        e.ref_fault[k]};
    end
    return s;
  endfunction

  // bus values are the ones held through the cycle, so no race with the driver
  always @(posedge clk_sys) begin
    if (rst) begin
      exp_f <= '0;
      exp_m <= '0;
      prev <= '0;
    end else begin
      clr = '0;
      ix = paddr[13:2];
      wr_ok = psel && penable && pready === 1'b1 && pwrite && pstrb[0] && paddr[15:14] == 2'h0 && paddr[1:0] == 2'h0;
      if (wr_ok && ix >= 12'ha04 && ix <= 12'ha09) clr[ix - 12'ha04] = pwdata[7:0];
      if (wr_ok && ix == 12'ha03 && pwdata[1]) clr = '1;
      if (wr_ok && ix >= 12'h209 && ix <= 12'h20e) exp_m[ix - 12'h209] <= pwdata[7:0] & VALID[ix - 12'h209];
      exp_f <= (exp_f & ~clr) | (set_of(evt, lvl, prev) & ~exp_m); // set wins over clear
      prev <= lvl;
    end
  end

  // expected {error, data} of a read
  function automatic logic [32:0] exp_rd(logic [15:0] a, logic [5:0][7:0] f);
    logic [11:0] i;
    i = a[13:2];
    if (a[1:0] != 2'h0 || a[15:14] != 2'h0) return {1'b1, 32'h0};
    if (i >= 12'hd02 && i <= 12'hd07) return {25'h0, f[i - 12'hd02]};
    if (i >= 12'h209 && i <= 12'h20e) return {25'h0, exp_m[i - 12'h209]};
    if ((i >= 12'ha03 && i <= 12'ha09) || i == 12'hd08 || i == 12'hd09) return 33'h0;
    return {1'b1, 32'h0};
  endfunction

  // ---------------------------------------------------------------------------
  // bus tasks and comparison
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] want, input string what);
    check_count++;
    if (got !== want) begin
      n_errors++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  // one transfer; snap is the model as it stood at the first access edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic [3:0] st,
                     output logic [32:0] res, output logic [5:0][7:0] snap);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    snap = exp_f;
    // no cycle count assumed here: only the watchdog ends a wait that never answers
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    res = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [15:0] a);
    logic [32:0] r;
    logic [5:0][7:0] s;
    apb(1'b0, a, 8'h00, 4'hf, r, s);
    chk(r, exp_rd(a, s), "read");
  endtask

  // a write is refused only where a read would be; its data bus is not judged
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] st);
    logic [32:0] r;
    logic [5:0][7:0] s;
    logic [32:0] e;
    apb(1'b1, a, d, st, r, s);
    e = exp_rd(a, s);
    chk({r[32], 32'h0}, {e[32], 32'h0}, "write response");
  endtask

  task automatic check_all();
    for (int i = 12'hd02; i <= 12'hd09; i++) rd({2'h0, i[11:0], 2'h0});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // random pulses and level toggles, only while enabled
  always @(posedge clk_sys) begin
    if (rnd_on) begin
      evt <= emfb_pkg::emfb_evt_type'($urandom & $urandom & $urandom);
      lvl <= lvl ^ emfb_pkg::emfb_lvl_type'(($urandom % 4 == 0) ? $urandom : 0);
    end
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    $display("Error at %0t: watchdog ran out before the tests ended", $time);
    close_out();
  end

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(18747));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // reset values, unused places and refused addresses
    check_all();
    for (int i = 12'h209; i <= 12'h20f; i++) rd({2'h0, i[11:0], 2'h0});
    for (int i = 12'ha03; i <= 12'ha0a; i++) rd({2'h0, i[11:0], 2'h0});
    rd(16'h3428);
    rd(16'h3409);
    rd(16'h7408);
    wr(16'h3409, 8'hff, 4'hf);
    $display("test reset_map done");
    // every pulse alone, then each level up and down
    for (int i = 0; i < $bits(emfb_pkg::emfb_evt_type); i++) begin
      evt <= emfb_pkg::emfb_evt_type'(1 << i);
      @(posedge clk_sys);
      evt <= '0;
      @(posedge clk_sys);
      check_all();
      wr(16'h280c, 8'h02, 4'hf);
    end
    for (int j = 0; j < $bits(emfb_pkg::emfb_lvl_type); j++) begin
      lvl <= emfb_pkg::emfb_lvl_type'(1 << j);
      @(posedge clk_sys);
      check_all();
      lvl <= '0;
      @(posedge clk_sys);
      check_all();
    end
    $display("test event_walk done");
    // software writes to flags and a clear without strobe change nothing
    evt <= '1;
    @(posedge clk_sys);
    evt <= '0;
    for (int i = 12'hd02; i <= 12'hd09; i++) wr({2'h0, i[11:0], 2'h0}, 8'h00, 4'hf);
    wr(16'h2810, 8'hff, 4'he);
    check_all();
    for (int i = 12'ha04; i <= 12'ha09; i++) begin
      wr({2'h0, i[11:0], 2'h0}, 8'h5a, 4'h1);
      check_all();
    end
    $display("test write_clear done");
    // masked events stay clear; flags set before the mask survive it
    for (int i = 12'h209; i <= 12'h20e; i++) wr({2'h0, i[11:0], 2'h0}, 8'hff, 4'hf);
    for (int i = 12'h209; i <= 12'h20e; i++) rd({2'h0, i[11:0], 2'h0});
    wr(16'h280c, 8'h02, 4'hf);
    evt <= '1;
    lvl <= '1;
    @(posedge clk_sys);
    evt <= '0;
    check_all();
    wr(16'h0824, 8'h00, 4'hf);
    evt <= '1;
    lvl <= '0;
    @(posedge clk_sys);
    evt <= '0;
    wr(16'h0824, 8'hff, 4'hf);
    check_all();
    $display("test mask done");
    // random traffic against random events
    rnd_on <= 1'b1;
    for (int n = 0; n < 400; n++) begin
      case ($urandom % 5)
        0: rd({2'h0, 12'hd02 + 12'($urandom % 8), 2'h0});
        1: wr({2'h0, 12'h209 + 12'($urandom % 7), 2'h0}, 8'($urandom), 4'($urandom));
        2: wr({2'h0, 12'ha04 + 12'($urandom % 6), 2'h0}, 8'($urandom), 4'($urandom));
        3: wr(16'h280c, 8'($urandom), 4'hf);
        default: wr({2'h0, 12'hd02 + 12'($urandom % 10), 2'h0}, 8'($urandom), 4'hf);
      endcase
    end
    $display("test random done");
    // reset in mid-run wipes flags and masks
    rnd_on <= 1'b0;
    @(posedge clk_sys);
    rst <= 1'b1;
    evt <= '0;
    lvl <= '0;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check_all();
    rd(16'h0824);
    $display("test mid_reset done");
    close_out();
  end
endmodule
`default_nettype wire
